// ===== verilog/pdqw_walker.sv
`timescale 1ns/1ns
`default_nettype none
module pdqw_walker
  import pdqw_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output pdqw_mem_t mem_o,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  output pdqw_job_t job_o,
  input wire logic job_done,
  input wire logic [15:0] job_bytes,
  output logic irq
);

  typedef struct packed {
    pdqw_state_t st;
    logic [3:0] ch;
    logic [1:0] wcnt;
    logic [3:0][31:0] desc;
    logic [31:0] cur;
    logic [31:0] first_addr;
    logic [31:0] first_w3;
    logic [15:0] pkt_acc;
    logic in_pkt;
    logic [NUM_CH-1:0][31:0] head;
    logic [NUM_CH-1:0] active;
    logic [1:0] ctrl;
    logic [NUM_CH-1:0] istat;
    logic [NUM_CH-1:0] imask;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    pdqw_mem_t mem;
    pdqw_job_t job;
  } pdqw_regs_t;

  pdqw_regs_t r_q;
  pdqw_regs_t r_d;

  // lowest ready channel wins; tx channels need tx enable, rx need rx enable
  function automatic logic [4:0] pdqw_pick(input logic [NUM_CH-1:0] act, input logic [1:0] en);
    logic [4:0] res;
    res = 5'h00;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (act[i] && en[(i >= 8) ? CTRL_RX_EN : CTRL_TX_EN]) begin
        res = {1'b1, 4'(i)};
      end
    end
    return res;
  endfunction : pdqw_pick

  function automatic pdqw_mem_t pdqw_rd(input logic [31:0] a);
    pdqw_mem_t m;
    m.req = 1'b1;
    m.we = 1'b0;
    m.addr = a;
    m.wdata = RST_WORD;
    return m;
  endfunction : pdqw_rd

  function automatic pdqw_mem_t pdqw_wr(input logic [31:0] a, input logic [31:0] d);
    pdqw_mem_t m;
    m.req = 1'b1;
    m.we = 1'b1;
    m.addr = a;
    m.wdata = d;
    return m;
  endfunction : pdqw_wr

  logic apb_xfer;
  logic [4:0] pick;
  logic [31:0] w2;
  logic [31:0] w3;
  logic is_last;
  logic [31:0] first_patch;

  assign apb_xfer = psel && penable && r_q.pready;
  assign pick = pdqw_pick(r_q.active, r_q.ctrl);
  assign w2 = r_q.desc[2];
  assign w3 = r_q.desc[3];
  assign is_last = w3[F_LAST];

  // patched flags word of the first descriptor: ownership handed back, rx length filled
  always_comb begin
    first_patch = r_q.first_w3;
    first_patch[F_HOLDS] = 1'b0;
    if (r_q.ch[3]) begin
      first_patch[15:0] = r_q.pkt_acc;
    end
    if (r_q.first_addr == r_q.cur && is_last && r_q.desc[0] == RST_WORD) begin
      first_patch[F_QFIN] = 1'b1;
    end
  end

  always_comb begin
    r_d = r_q;
    r_d.pready = 1'b0;
    r_d.pslverr = 1'b0;
    r_d.prdata = RST_WORD;

    // apb slave: one wait state, effects at the completing edge
    if (psel && penable && !r_q.pready) begin
      r_d.pready = 1'b1;
      if (paddr[1:0] != 2'b00) begin
        r_d.pslverr = 1'b1;
      end else if (paddr < OFF_CTRL) begin
        r_d.prdata = r_q.head[paddr[5:2]];
      end else begin
        unique case (paddr)
          OFF_CTRL: r_d.prdata = {30'h0000_0000, r_q.ctrl};
          OFF_INT_STAT: r_d.prdata = {16'h0000, r_q.istat};
          OFF_INT_MASK: r_d.prdata = {16'h0000, r_q.imask};
          OFF_ACTIVE: r_d.prdata = {16'h0000, r_q.active};
          default: r_d.pslverr = 1'b1;
        endcase
      end
    end
    if (apb_xfer && pwrite && paddr[1:0] == 2'b00) begin
      if (paddr < OFF_CTRL) begin
        // a zero write parks the channel; nonzero starts the chain there
        r_d.head[paddr[5:2]] = pwdata;
        r_d.active[paddr[5:2]] = (pwdata != RST_WORD);
      end else if (paddr == OFF_CTRL) begin
        r_d.ctrl = pwdata[1:0];
      end else if (paddr == OFF_INT_STAT) begin
        r_d.istat = r_q.istat & ~pwdata[NUM_CH-1:0];
      end else if (paddr == OFF_INT_MASK) begin
        r_d.imask = pwdata[NUM_CH-1:0];
      end
    end

    unique case (r_q.st)
      S_IDLE: begin
        // a packet in progress keeps its channel so fragments stay in order
        if (r_q.in_pkt && r_q.active[r_q.ch]) begin
          r_d.cur = r_q.head[r_q.ch];
          r_d.mem = pdqw_rd(r_q.head[r_q.ch] + W0_NEXT);
          r_d.wcnt = 2'd0;
          r_d.st = S_FETCH;
        end else if (r_q.in_pkt) begin
          r_d.in_pkt = 1'b0;
        end else if (pick[4]) begin
          r_d.ch = pick[3:0];
          r_d.cur = r_q.head[pick[3:0]];
          r_d.mem = pdqw_rd(r_q.head[pick[3:0]] + W0_NEXT);
          r_d.wcnt = 2'd0;
          r_d.st = S_FETCH;
        end
      end
      S_FETCH: begin
        if (mem_ack) begin
          r_d.desc[r_q.wcnt] = mem_rdata;
          if (r_q.wcnt == 2'd3) begin
            r_d.mem.req = 1'b0;
            if (!r_q.in_pkt && !(mem_rdata[F_FIRST] && mem_rdata[F_HOLDS])) begin
              // not a first descriptor we own: stop the channel rather than guess
              r_d.active[r_q.ch] = 1'b0;
              r_d.st = S_IDLE;
            end else begin
              if (!r_q.in_pkt) begin
                r_d.first_addr = r_q.cur;
                r_d.first_w3 = mem_rdata;
                r_d.pkt_acc = RST_16;
                r_d.in_pkt = 1'b1;
              end
              r_d.job.valid = 1'b1;
              r_d.job.rx = r_q.ch[3];
              r_d.job.chan = r_q.ch[2:0];
              r_d.job.first = !r_q.in_pkt;
              r_d.job.last = mem_rdata[F_LAST];
              r_d.job.len = w2[15:0];
              // offset and packet length only count on the first descriptor, where the buffer holds data
              if (!r_q.in_pkt && !r_q.ch[3]) begin
                r_d.job.addr = r_q.desc[1] + {16'h0000, w2[31:16]};
                r_d.job.pkt_len = mem_rdata[15:0];
              end else begin
                r_d.job.addr = r_q.desc[1];
                r_d.job.pkt_len = RST_16;
              end
              r_d.st = S_JOB;
            end
          end else begin
            r_d.wcnt = r_q.wcnt + 2'd1;
            r_d.mem.addr = r_q.mem.addr + 32'h0000_0004;
          end
        end
      end
      S_JOB: begin
        if (job_done) begin
          r_d.job.valid = 1'b0;
          r_d.pkt_acc = r_q.ch[3] ? 16'(r_q.pkt_acc + job_bytes) : r_q.pkt_acc;
          if (!is_last) begin
            r_d.st = S_ADV;
          end else if (r_q.desc[0] == RST_WORD && r_q.first_addr != r_q.cur) begin
            r_d.mem = pdqw_wr(r_q.cur + W3_FLAGS, w3 | (32'h1 << F_QFIN));
            r_d.st = S_QFIN;
          end else begin
            r_d.st = S_FIRST;
          end
        end
      end
      S_QFIN: begin
        if (mem_ack) begin
          r_d.mem.req = 1'b0;
          r_d.st = S_FIRST;
        end
      end
      S_FIRST: begin
        // issue on entry, retire on ack
        if (!r_q.mem.req) begin
          r_d.mem = pdqw_wr(r_q.first_addr + W3_FLAGS, first_patch);
        end else if (mem_ack) begin
          r_d.mem.req = 1'b0;
          r_d.istat[r_q.ch] = 1'b1;
          r_d.in_pkt = 1'b0;
          r_d.st = S_ADV;
        end
      end
      S_ADV: begin
        r_d.head[r_q.ch] = r_q.desc[0];
        // zero next pointer is the only end mark; channel then waits for software
        if (r_q.desc[0] == RST_WORD) begin
          r_d.active[r_q.ch] = 1'b0;
          r_d.in_pkt = 1'b0;
        end
        r_d.st = S_IDLE;
      end
    endcase

    // hardware set wins over a same-cycle software clear
    if (r_q.st == S_FIRST && r_q.mem.req && mem_ack) begin
      r_d.istat[r_q.ch] = 1'b1;
    end
    r_d.irq = |(r_d.istat & r_d.imask);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      r_q <= '0;
      r_q.st <= S_IDLE;
    end else if (ce) begin
      r_q <= r_d;
    end
  end

  assign prdata = r_q.prdata;
  assign pready = r_q.pready;
  assign pslverr = r_q.pslverr;
  assign mem_o = r_q.mem;
  assign job_o = r_q.job;
  assign irq = r_q.irq;

endmodule : pdqw_walker
`default_nettype wire

// ===== verilog/pdqw_pkg.sv
// Functional notes
// - descriptor is four words: next, buffer, offset/length, flags/packet length
// - first descriptor of a packet carries packet_first_flag
// - last descriptor of a packet carries packet_last_flag; single buffer has both
// - buffer pointer is tx data source or rx empty buffer
// - buffer offset skips leading bytes, only where the buffer holds data; the engine applies it on first tx descriptors only
// - buffer length is valid bytes, or capacity of an empty rx buffer
// - packet length used only on first descriptors holding data
// - eight tx and eight rx channels, each with its own head register
// - hardware_holds_flag lives only on the first descriptor of a packet
// - after the last descriptor, patch first descriptor clearing hardware_holds_flag
// - writing a head register starts the chain from that descriptor
// - a zero next pointer is the only end-of-list mark
// - last descriptor with zero next pointer gets queue_finished_flag set
package pdqw_pkg;
  localparam int unsigned NUM_CH = 16;
  localparam logic [7:0] OFF_TX_HEAD = 8'h00;
  localparam logic [7:0] OFF_RX_HEAD = 8'h20;
  localparam logic [7:0] OFF_CTRL = 8'h40;
  localparam logic [7:0] OFF_INT_STAT = 8'h44;
  localparam logic [7:0] OFF_INT_MASK = 8'h48;
  localparam logic [7:0] OFF_ACTIVE = 8'h4c;
  localparam int unsigned CTRL_TX_EN = 0;
  localparam int unsigned CTRL_RX_EN = 1;
  localparam logic [31:0] W0_NEXT = 32'h0000_0000;
  localparam logic [31:0] W3_FLAGS = 32'h0000_000c;
  localparam int unsigned F_FIRST = 31;
  localparam int unsigned F_LAST = 30;
  localparam int unsigned F_HOLDS = 29;
  localparam int unsigned F_QFIN = 28;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [15:0] RST_16 = 16'h0000;

  typedef enum logic [5:0] {
    S_IDLE = 6'b000001,
    S_FETCH = 6'b000010,
    S_JOB = 6'b000100,
    S_QFIN = 6'b001000,
    S_FIRST = 6'b010000,
    S_ADV = 6'b100000
  } pdqw_state_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } pdqw_mem_t;

  typedef struct packed {
    logic valid;
    logic rx;
    logic [2:0] chan;
    logic [31:0] addr;
    logic [15:0] len;
    logic [15:0] pkt_len;
    logic first;
    logic last;
  } pdqw_job_t;
endpackage : pdqw_pkg

// ===== dv/pdqw_walker_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module pdqw_walker_asserts
  import pdqw_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  input wire pdqw_mem_t mem_o,
  input wire logic mem_ack,
  input wire pdqw_job_t job_o,
  input wire logic job_done,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  // a frozen cycle moves nothing, so step checks pause while ce is low
  default disable iff (srst || !ce);
  sequence s_rd;
    mem_o.req && !mem_o.we;
  endsequence
  property p_rdy; psel && penable && !pready |=> pready; endproperty
  property p_pulse; pready |=> !pready; endproperty
  property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
  property p_mhold; mem_o.req && !mem_ack |=> mem_o.req && $stable(mem_o.addr); endproperty
  property p_walk;
    s_rd ##0 (mem_ack && mem_o.addr[3:0] != 4'hc) |=> s_rd ##0 (mem_o.addr == $past(mem_o.addr) + 32'h4);
  endproperty
  property p_wb; mem_o.req && mem_o.we |-> mem_o.addr[3:0] == 4'hc && !mem_o.wdata[F_HOLDS]; endproperty
  property p_qfin; mem_o.req && mem_o.we && mem_o.wdata[F_QFIN] |-> mem_o.wdata[F_LAST]; endproperty
  property p_jhold; job_o.valid && !job_done |=> $stable(job_o); endproperty
  property p_jdrop; job_o.valid && job_done |=> !job_o.valid; endproperty
  property p_rst; disable iff (1'b0) srst |=> !mem_o.req && !job_o.valid && !irq; endproperty
  a_rdy: assert property (p_rdy) else $error("pready late");
  a_pulse: assert property (p_pulse) else $error("pready too long");
  a_err: assert property (p_err) else $error("error answer bad");
  a_mhold: assert property (p_mhold) else $error("memory request moved");
  a_walk: assert property (p_walk) else $error("descriptor word order");
  a_wb: assert property (p_wb) else $error("bad write back");
  a_qfin: assert property (p_qfin) else $error("queue end off packet end");
  a_jhold: assert property (p_jhold) else $error("job moved");
  a_jdrop: assert property (p_jdrop) else $error("job not dropped");
  a_rst: assert property (p_rst) else $error("reset outputs");
endmodule : pdqw_walker_asserts
bind pdqw_walker pdqw_walker_asserts u_asserts (.clk, .srst, .ce, .psel, .penable, .pready,
  .pslverr, .prdata, .mem_o, .mem_ack, .job_o, .job_done, .irq);
`default_nettype wire

// ===== dv/pdqw_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
module pdqw_mem_model
  import pdqw_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire pdqw_mem_t mem_i,
  input wire logic [1:0] lat,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [31:0] mem [0:1023];
  logic [1:0] wait_q;
  // plain always: the bench preloads descriptors straight into mem
  always @(posedge clk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata; // stale data never lingers
    if (srst) begin
      wait_q <= 2'h0;
      mem_rdata <= 32'h0;
    end else if (mem_i.req && !mem_ack) begin
      wait_q <= wait_q + 2'h1;
      if (wait_q == lat) begin
        wait_q <= 2'h0;
        mem_ack <= 1'b1;
        mem_rdata <= mem[mem_i.addr[11:2]];
        if (mem_i.we) begin
          mem[mem_i.addr[11:2]] <= mem_i.wdata;
        end
      end
    end
  end
endmodule : pdqw_mem_model
`default_nettype wire

// ===== dv/pdqw_walker_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module pdqw_walker_tb_top
  import pdqw_pkg::*;
;
  logic clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, job_done = 1'b0;
  logic ce = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, mem_rdata, r;
  logic [15:0] job_bytes = 16'h0008;
  logic [1:0] lat = 2'h0;
  logic pready, pslverr, mem_ack, irq, e;
  pdqw_mem_t mem_o;
  pdqw_job_t job_o;
  pdqw_job_t jq[$];
  int bad_count = 0, samples_checked = 0;
  always #20 clk = ~clk;
  pdqw_walker u_dut (.clk, .srst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .mem_o, .mem_ack, .mem_rdata, .job_o, .job_done,
    .job_bytes, .irq);
  pdqw_mem_model u_mem (.clk, .srst, .mem_i(mem_o), .lat, .mem_ack, .mem_rdata);
  always @(posedge clk) begin
    job_done <= job_o.valid && !job_done;
    if (job_o.valid && job_done) begin
      jq.push_back(job_o);
    end
  end
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s exp %h got %h", n, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no cycle count assumed; only the watchdog ends a wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(n, r, exp);
  endtask : rdc
  task automatic idle_wait;
    int k;
    k = 0;
    do begin
      apb(1'b0, OFF_ACTIVE, 32'h0);
      k++;
    end while (r !== 32'h0 && k < 200);
    chk("idle", r, 32'h0);
  endtask : idle_wait
  task automatic desc(input logic [31:0] a, n, b, ol, fl);
    u_mem.mem[a[11:2]] = n;
    u_mem.mem[a[11:2] + 10'd1] = b;
    u_mem.mem[a[11:2] + 10'd2] = ol;
    u_mem.mem[a[11:2] + 10'd3] = fl;
  endtask : desc
  task automatic close_out;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    close_out;
  end
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, 8'(i * 4), 32'h0);
      rdc("head", 8'(i * 4), 32'h0);
    end
    apb(1'b0, 8'h50, 32'h0);
    chk("unmapped", {31'h0, e}, 32'h1);
    apb(1'b1, OFF_CTRL, 32'h3);
    apb(1'b1, OFF_INT_MASK, 32'h200);
    desc(32'h100, 32'h0, 32'h1000, 32'h0004_0010, 32'he000_0010);
    apb(1'b1, OFF_TX_HEAD, 32'h100);
    idle_wait;
    chk("tx addr", jq[0].addr, 32'h1004);
    chk("tx lens", {jq[0].pkt_len, jq[0].len}, 32'h0010_0010);
    chk("tx wb", u_mem.mem[10'h43], 32'hd000_0010);
    rdc("tx head", OFF_TX_HEAD, 32'h0);
    chk("irq masked", {31'h0, irq}, 32'h0);
    rdc("stat", OFF_INT_STAT, 32'h1);
    apb(1'b1, OFF_INT_STAT, 32'h1);
    rdc("stat clr", OFF_INT_STAT, 32'h0);
    lat <= 2'h3;
    desc(32'h200, 32'h210, 32'h2000, 32'h40, 32'ha000_0000);
    desc(32'h210, 32'h0, 32'h3000, 32'h40, 32'h4000_0000);
    apb(1'b1, OFF_RX_HEAD + 8'h4, 32'h200);
    ce <= 1'b0;
    repeat (6) @(posedge clk);
    chk("ce freeze", mem_o.addr, 32'h200);
    ce <= 1'b1;
    idle_wait;
    chk("jobs", 32'(jq.size()), 32'h3);
    chk("rx addr", jq[2].addr, 32'h3000);
    chk("rx job", {12'h0, jq[1].rx, jq[1].chan, jq[1].len}, 32'h0009_0040);
    chk("rx first wb", u_mem.mem[10'h83], 32'h8000_0010);
    chk("rx last wb", u_mem.mem[10'h87], 32'h5000_0000);
    chk("irq", {31'h0, irq}, 32'h1);
    apb(1'b1, OFF_INT_STAT, 32'h200);
    @(posedge clk);
    chk("irq clr", {31'h0, irq}, 32'h0);
    desc(32'h300, 32'h310, 32'h4000, 32'h20, 32'he000_0020);
    desc(32'h310, 32'h0, 32'h4100, 32'h20, 32'he000_0020);
    desc(32'h320, 32'h0, 32'h4200, 32'h20, 32'he000_0020);
    apb(1'b1, OFF_TX_HEAD + 8'h8, 32'h300);
    u_mem.mem[10'hc4] = 32'h320;
    idle_wait;
    chk("append jobs", 32'(jq.size()), 32'h6);
    chk("append end", jq[5].addr, 32'h4200);
    chk("append mid wb", u_mem.mem[10'hc7], 32'hc000_0020);
    chk("append last wb", u_mem.mem[10'hcb], 32'hd000_0020);
    desc(32'h330, 32'h0, 32'h4300, 32'h20, 32'he000_0020);
    desc(32'h340, 32'h0, 32'h4400, 32'h20, 32'he000_0020);
    apb(1'b1, OFF_TX_HEAD + 8'h8, 32'h330);
    idle_wait;
    // patched too late: the engine has already stopped on this channel
    u_mem.mem[10'hcc] = 32'h340;
    repeat (20) @(posedge clk);
    chk("late append", 32'(jq.size()), 32'h7);
    chk("missed eoq", u_mem.mem[10'hcf], 32'hd000_0020);
    apb(1'b1, OFF_TX_HEAD + 8'h8, 32'h340);
    idle_wait;
    chk("resubmit", u_mem.mem[10'hd3], 32'hd000_0020);
    desc(32'h350, 32'h0, 32'h4500, 32'h20, 32'hc000_0020);
    apb(1'b1, OFF_TX_HEAD + 8'h8, 32'h350);
    idle_wait;
    chk("not owned", u_mem.mem[10'hd7], 32'hc000_0020);
    chk("not owned jobs", 32'(jq.size()), 32'h8);
    apb(1'b1, OFF_CTRL, 32'h1);
    desc(32'h360, 32'h0, 32'h4600, 32'h20, 32'he000_0020);
    apb(1'b1, OFF_RX_HEAD, 32'h360);
    repeat (40) @(posedge clk);
    rdc("rx held", OFF_ACTIVE, 32'h0000_0100);
    apb(1'b1, OFF_CTRL, 32'h3);
    idle_wait;
    chk("rx jobs", 32'(jq.size()), 32'h9);
    chk("rx len wb", u_mem.mem[10'hdb], 32'hd000_0008);
    close_out;
  end
endmodule : pdqw_walker_tb_top
`default_nettype wire
